// file: pmsc_top.v
// Power management status and control register block with APB slave
//
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/1ps
// How it works
// - Detect flag at bit 7 reads the latched undervolt event, only while detect logic is on.
// - Writing one to bit 6 clears the detect flag; bit 6 always reads zero.
// - With bit 5 set an interrupt is requested while the detect flag is set.
// - With bit 4 set and detect logic on, a set detect flag forces a device reset.
// - Bit 3 decides whether detection keeps running in stop, only while detect logic is on.
// - Bit 2 turns the detect logic on and qualifies the other detect controls.
// - Write-once bits take the first write after reset and ignore later writes.
// - Warning flag sets when supply is below the warning point, also right after reset.
// - Writing one to bit 6 clears the warning flag only if the warning is gone.
// - Bit 5 selects the detect trip point, one meaning high, driven to the detector.
// - Bit 4 selects the warning trip point, one meaning high, driven to the comparator.
// - Partial sleep exit flag sets on stop2 recovery and clears by writing one to bit 2.
// - Write-once bit 1 allows stop1 and stop2 entry when one, blocks them when zero.
// - Write-once bit 0 selects stop2 when one and stop1 when zero, only if allowed.
module pmsc_top (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire        clk_en,
  input  wire        por_n,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // Analog comparators and power state
  input  wire        undervolt_cmp,
  input  wire        warning_cmp,
  input  wire        stop_active,
  input  wire        stop2_wake,
  // Controls out
  output reg         undervolt_trip_select,
  output reg         warning_trip_select,
  output reg         undervolt_detect_on,
  output reg         deep_sleep_allow,
  output reg         deep_sleep_kind_select,
  output reg         undervolt_reset_req,
  output reg         irq
);
`include "pmsc_defs.vh"
  // ==========================================================
  // Synchronisers
  localparam SYNC_N = 4;
  wire [SYNC_N-1:0] sync_in;
  wire [SYNC_N-1:0] sync_out;
  reg               wk_prev_q;
  assign sync_in = {por_n, stop2_wake, warning_cmp, undervolt_cmp};
  genvar g;
  generate
    for (g = 0; g < SYNC_N; g = g + 1) begin : g_sync
      reg [1:0] ff_q;
      always @(posedge clk_sys) begin
        if (clk_en) begin
          ff_q <= {ff_q[0], sync_in[g]};
        end
      end
      assign sync_out[g] = ff_q[1];
    end
  endgenerate
  // Wake edge detector reads only the second stage
  always @(posedge clk_sys) begin
    if (clk_en) begin
      wk_prev_q <= sync_out[2];
    end
  end
  wire uv_s   = sync_out[0];
  wire wn_s   = sync_out[1];
  wire por_s  = ~sync_out[3];
  wire wake_p = sync_out[2] & ~wk_prev_q;
  // ==========================================================
  // Bus decode
  wire       acc    = psel & penable & ~pready;
  wire       wr     = acc & pwrite;
  wire       rd     = acc & ~pwrite;
  wire       a_det  = (paddr == `PMSC_ADDR_DETECT);
  wire       a_wrn  = (paddr == `PMSC_ADDR_WARN);
  wire       a_ist  = (paddr == `PMSC_ADDR_IRQ_ST);
  wire       a_msk  = (paddr == `PMSC_ADDR_IRQ_MSK);
  wire       a_sts  = (paddr == `PMSC_ADDR_STATUS);
  wire       mapped = a_det | a_wrn | a_ist | a_msk | a_sts;
  wire       wr_det = wr & a_det;
  wire       wr_wrn = wr & a_wrn;
  // ==========================================================
  // Registers
  reg  [7:0] det_q;
  reg        det_flag_q;
  reg        wrn_flag_q;
  reg        ppd_flag_q;
  reg        dtrip_q;
  reg        wtrip_q;
  reg        pda_q;
  reg        kind_q;
  reg        once_q;
  reg  [2:0] ist_q;
  reg  [2:0] msk_q;
  reg        por_seen_q;
  wire       det_en  = det_q[`PMSC_DET_EN];
  wire       det_run = det_en & (~stop_active | det_q[`PMSC_DET_SE]);
  wire       det_set = det_run & uv_s;
  wire       det_clr = wr_det & pwdata[`PMSC_DET_CLR];
  wire       wrn_clr = wr_wrn & pwdata[`PMSC_WRN_CLR] & ~wn_s;
  wire       ppd_clr = wr_wrn & pwdata[`PMSC_WRN_PCLR];
  wire [2:0] ev      = {wake_p, wn_s & ~wrn_flag_q, det_set & ~det_flag_q};
  wire [2:0] ist_clr = (wr & a_ist) ? pwdata[2:0] : `PMSC_IRQ_RST;
  // Trip selects survive every reset except power-on
  always @(posedge clk_sys) begin
    if (clk_en) begin
      if (por_s) begin
        dtrip_q <= 1'b0;
        wtrip_q <= 1'b0;
      end else if (wr_wrn) begin
        dtrip_q <= pwdata[`PMSC_WRN_DTRIP];
        wtrip_q <= pwdata[`PMSC_WRN_WTRIP];
      end
    end
  end
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      det_q      <= `PMSC_DET_RST;
      det_flag_q <= 1'b0;
      wrn_flag_q <= 1'b0;
      ppd_flag_q <= 1'b0;
      pda_q      <= 1'b0;
      kind_q     <= 1'b0;
      once_q     <= 1'b0;
      ist_q      <= `PMSC_IRQ_RST;
      msk_q      <= `PMSC_IRQ_RST;
      por_seen_q <= 1'b0;
    end else if (clk_en) begin
      if (wr_det) begin
        det_q[`PMSC_DET_IE] <= pwdata[`PMSC_DET_IE];
        det_q[`PMSC_DET_RE] <= pwdata[`PMSC_DET_RE];
        det_q[`PMSC_DET_SE] <= pwdata[`PMSC_DET_SE];
        det_q[`PMSC_DET_EN] <= pwdata[`PMSC_DET_EN];
      end
      // Set wins over clear
      if (det_set)
        det_flag_q <= 1'b1;
      else if (det_clr | ~det_en)
        det_flag_q <= 1'b0;
      if (wn_s)
        wrn_flag_q <= 1'b1;
      else if (wrn_clr)
        wrn_flag_q <= 1'b0;
      if (wake_p)
        ppd_flag_q <= 1'b1;
      else if (ppd_clr)
        ppd_flag_q <= 1'b0;
      if (wr_wrn && !once_q) begin
        pda_q  <= pwdata[`PMSC_WRN_PDA];
        kind_q <= pwdata[`PMSC_WRN_KIND];
        once_q <= 1'b1;
      end
      if (wr & a_msk)
        msk_q <= pwdata[2:0];
      ist_q <= ev | (ist_q & ~ist_clr);
      if (por_s)
        por_seen_q <= 1'b1;
      else if (wr & a_sts & pwdata[`PMSC_ST_POR])
        por_seen_q <= 1'b0;
    end
  end
  // ==========================================================
  // Read mux
  reg  [31:0] rdata;
  always @* begin
    rdata = 32'h0000_0000;
    case (1'b1)
      a_det: begin
        rdata[`PMSC_DET_FLAG] = det_flag_q & det_en;
        rdata[`PMSC_DET_IE]   = det_q[`PMSC_DET_IE];
        rdata[`PMSC_DET_RE]   = det_q[`PMSC_DET_RE];
        rdata[`PMSC_DET_SE]   = det_q[`PMSC_DET_SE];
        rdata[`PMSC_DET_EN]   = det_q[`PMSC_DET_EN];
      end
      a_wrn: begin
        rdata[`PMSC_WRN_FLAG]  = wrn_flag_q;
        rdata[`PMSC_WRN_DTRIP] = dtrip_q;
        rdata[`PMSC_WRN_WTRIP] = wtrip_q;
        rdata[`PMSC_WRN_PFLAG] = ppd_flag_q;
        rdata[`PMSC_WRN_PDA]   = pda_q;
        rdata[`PMSC_WRN_KIND]  = kind_q;
      end
      a_ist: rdata[2:0] = ist_q;
      a_msk: rdata[2:0] = msk_q;
      a_sts: rdata[`PMSC_ST_POR] = por_seen_q;
      default: rdata = 32'h0000_0000;
    endcase
  end
  // ==========================================================
  // Outputs and APB answer
  always @(posedge clk_sys) begin
    if (!reset_n) begin
      prdata                 <= 32'h0000_0000;
      pready                 <= 1'b0;
      pslverr                <= 1'b0;
      undervolt_detect_on    <= 1'b0;
      deep_sleep_allow       <= 1'b0;
      deep_sleep_kind_select <= 1'b0;
      undervolt_reset_req    <= 1'b0;
      irq                    <= 1'b0;
    end else if (clk_en) begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      if (rd)
        prdata <= rdata;
      undervolt_detect_on    <= det_run;
      deep_sleep_allow       <= pda_q;
      deep_sleep_kind_select <= pda_q & kind_q;
      undervolt_reset_req    <= det_en & det_q[`PMSC_DET_RE] & det_flag_q;
      irq <= (det_q[`PMSC_DET_IE] & det_en & det_flag_q)
           | (|(ist_q & msk_q));
    end
  end
  // Trip selects are driven straight from their flip-flops
  always @* begin
    undervolt_trip_select = dtrip_q;
    warning_trip_select   = wtrip_q;
  end
endmodule // pmsc_top

// file: pmsc_defs.vh
// Constants for the power management status and control block
`ifndef PMSC_DEFS_VH
`define PMSC_DEFS_VH
// Register byte addresses
`define PMSC_ADDR_DETECT  12'h000
`define PMSC_ADDR_WARN    12'h004
`define PMSC_ADDR_IRQ_ST  12'h008
`define PMSC_ADDR_IRQ_MSK 12'h00C
`define PMSC_ADDR_STATUS  12'h010
// Detect control fields
`define PMSC_DET_FLAG     7
`define PMSC_DET_CLR      6
`define PMSC_DET_IE       5
`define PMSC_DET_RE       4
`define PMSC_DET_SE       3
`define PMSC_DET_EN       2
// Warning and stop control fields
`define PMSC_WRN_FLAG     7
`define PMSC_WRN_CLR      6
`define PMSC_WRN_DTRIP    5
`define PMSC_WRN_WTRIP    4
`define PMSC_WRN_PFLAG    3
`define PMSC_WRN_PCLR     2
`define PMSC_WRN_PDA      1
`define PMSC_WRN_KIND     0
// Interrupt status fields
`define PMSC_IRQ_DET      0
`define PMSC_IRQ_WRN      1
`define PMSC_IRQ_PPD      2
`define PMSC_IRQ_W        3
// Reset values
`define PMSC_DET_RST      8'h00
`define PMSC_IRQ_RST      3'h0
// Status fields
`define PMSC_ST_POR       0
`endif

// file: pmsc_chk_sva.sv
// Assertion checker for the power management register block
`timescale 1ns/1ps
module pmsc_chk (
  // Clock, reset and bus
  input wire        clk_sys, reset_n, por_n, psel, penable, pwrite, pready,
  input wire [11:0] paddr,
  input wire [31:0] prdata, pwdata,
  // Stop state and controls out
  input wire        stop_active, irq, undervolt_trip_select, warning_trip_select,
  input wire        undervolt_detect_on, deep_sleep_allow, deep_sleep_kind_select,
  input wire        undervolt_reset_req
);
  // ==========
  // Helper state
  reg  [1:0] trip_q;
  reg        once_q, once2_q;
  wire       done = psel && penable && pready;
  wire       wr4  = done && pwrite && paddr == 12'h004;
  wire       rd0  = done && !pwrite && paddr == 12'h000;
  wire       rd4  = done && !pwrite && paddr == 12'h004;
  always @(posedge clk_sys) begin
    if (wr4) trip_q <= pwdata[5:4];
    once_q  <= reset_n && (once_q || wr4);
    once2_q <= reset_n && once_q;
  end
  // ==========
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  property p_trd; wr4 |-> ##[1:2] undervolt_trip_select == trip_q[1]; endproperty
  a_trd: assert property (p_trd) else $error("detect trip wrong");
  property p_trw; wr4 |-> ##[1:2] warning_trip_select == trip_q[0]; endproperty
  a_trw: assert property (p_trw) else $error("warning trip wrong");
  property p_once; once2_q |-> $stable({deep_sleep_allow, deep_sleep_kind_select}); endproperty
  a_once: assert property (p_once) else $error("write-once changed");
  property p_kind; deep_sleep_kind_select |-> deep_sleep_allow; endproperty
  a_kind: assert property (p_kind) else $error("kind without allow");
  property p_rst;
    !stop_active && !$past(stop_active) && undervolt_reset_req |-> undervolt_detect_on;
  endproperty
  a_rst: assert property (p_rst) else $error("reset without detect");
  property p_ack; rd0 |-> prdata[31:8] == 24'h0 && !prdata[6]; endproperty
  a_ack: assert property (p_ack) else $error("detect clear reads one");
  property p_flag; rd0 && prdata[7] |-> prdata[2]; endproperty
  a_flag: assert property (p_flag) else $error("flag while disabled");
  property p_wack; rd4 |-> !prdata[6] && !prdata[2] && prdata[31:8] == 24'h0; endproperty
  a_wack: assert property (p_wack) else $error("clear bits read one");
  property p_keep;
    disable iff (!por_n) !reset_n |=> $stable({undervolt_trip_select, warning_trip_select});
  endproperty
  a_keep: assert property (p_keep) else $error("trip lost on reset");
  property p_clr;
    disable iff (!por_n) !reset_n |=> !deep_sleep_allow && !undervolt_reset_req && !irq;
  endproperty
  a_clr: assert property (p_clr) else $error("output kept on reset");
  c_irq: cover property ($rose(irq));
  c_req: cover property ($rose(undervolt_reset_req));
  c_kind: cover property (deep_sleep_kind_select);
endmodule // pmsc_chk
bind pmsc_top pmsc_chk u_chk (.*);

// file: pmsc_cmp_model.sv
// Supply comparator model: level rises as the supply drops
`timescale 1ns/1ps
module pmsc_cmp_model (
  input wire [1:0] supply_lvl,
  input wire       undervolt_trip_select, warning_trip_select,
  output reg       undervolt_cmp, warning_cmp
);
  always @(supply_lvl or undervolt_trip_select or warning_trip_select) begin
    undervolt_cmp <= #23 supply_lvl >= (undervolt_trip_select ? 2'h2 : 2'h3);
    warning_cmp <= #31 supply_lvl >= (warning_trip_select ? 2'h1 : 2'h2);
  end
endmodule // pmsc_cmp_model

// file: tb.sv
// Self-checking testbench for the power management register block
`timescale 1ns/1ps
module tb;
  reg        clk_sys, reset_n, por_n, psel, penable, pwrite, stop_active, stop2_wake, e;
  reg [11:0] paddr;
  reg [31:0] pwdata, q;
  reg [1:0]  supply_lvl;
  reg [7:0]  v;
  wire       clk_en = 1'b1;
  wire [31:0] prdata;
  wire       pready, pslverr, undervolt_cmp, warning_cmp, undervolt_trip_select;
  wire       warning_trip_select, undervolt_detect_on, deep_sleep_allow;
  wire       deep_sleep_kind_select, undervolt_reset_req, irq;
  integer    err_total, cmp_count, i;
  pmsc_top DUT (.*);
  pmsc_cmp_model u_cmp (.*);
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task conclude;
    begin
      $display("compares %0d errors %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask
  task chk(input [31:0] s, input [31:0] x);
    begin
      cmp_count = cmp_count + 1;
      if (s !== x) begin
        err_total = err_total + 1;
        $display("ERROR %0t got %h want %h", $time, s, x);
      end
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_sys);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      n = 0;
      do begin @(posedge clk_sys); n = n + 1; end while (pready !== 1'b1 && n < 20);
      if (n == 20) begin err_total = err_total + 1; conclude; end
      q = prdata; e = pslverr; psel <= 1'b0; penable <= 1'b0;
    end
  endtask
  task rd(input [11:0] a, input [31:0] x); begin apb(1'b0, a, 32'h0); chk(q, x); end endtask
  task tick(input integer n); repeat (n) @(posedge clk_sys); endtask
  function below(input [1:0] l, input hi, input det);
    below = l >= (det ? (hi ? 2'h2 : 2'h3) : (hi ? 2'h1 : 2'h2));
  endfunction
  initial begin
    err_total = 0; cmp_count = 0; psel = 0; penable = 0; pwrite = 0; paddr = 12'h000;
    pwdata = 32'h0; stop_active = 0; stop2_wake = 0; supply_lvl = 2'h0; por_n = 0; reset_n = 0;
    v = $urandom(32'h8df02648);
    tick(5); por_n <= 1; reset_n <= 1;
    rd(12'h000, 32'h0);
    apb(1'b0, 12'h014, 32'h0); chk({31'h0, e}, 32'h1);
    for (i = 0; i < 6; i = i + 1) begin
      v = $urandom; apb(1'b1, 12'h000, {24'h0, v & 8'hFC}); stop_active <= v[1]; tick(3);
      chk(undervolt_detect_on, v[2] & (~v[1] | v[3]));
      rd(12'h000, {24'h0, v & 8'h3C});
    end
    stop_active <= 0; v = $urandom;
    apb(1'b1, 12'h004, {31'h19, ~v[0]}); tick(2);
    chk({undervolt_trip_select, warning_trip_select, deep_sleep_allow, deep_sleep_kind_select}, {3'h7, ~v[0]});
    apb(1'b1, 12'h004, {31'h18, v[0]}); tick(2);
    chk({deep_sleep_allow, deep_sleep_kind_select}, {1'b1, ~v[0]});
    apb(1'b1, 12'h000, 32'h34);
    for (i = 1; i < 4; i = i + 1) begin
      supply_lvl <= i; tick(6);
      rd(12'h004, {24'h0, below(i, 1, 0), 6'h19, ~v[0]});
      rd(12'h000, {24'h0, below(i, 1, 1), 7'h34});
      chk({irq, undervolt_reset_req}, {2{below(i, 1, 1)}});
    end
    apb(1'b1, 12'h004, 32'h70); rd(12'h004, {24'h0, 7'h59, ~v[0]});
    supply_lvl <= 0; tick(6); apb(1'b1, 12'h004, 32'h70); apb(1'b1, 12'h000, 32'h74);
    rd(12'h004, {31'h19, ~v[0]});
    rd(12'h000, 32'h34); chk(irq, 0);
    rd(12'h008, 32'h3); apb(1'b1, 12'h00C, 32'h7); tick(2); chk(irq, 1);
    apb(1'b1, 12'h008, 32'h7); tick(2); chk(irq, 0);
    stop2_wake <= 1; tick(4); stop2_wake <= 0; tick(2);
    rd(12'h004, {31'h1D, ~v[0]}); apb(1'b1, 12'h004, 32'h34);
    rd(12'h004, {31'h19, ~v[0]});
    reset_n <= 0; tick(2); reset_n <= 1; tick(1);
    chk({undervolt_trip_select, warning_trip_select, deep_sleep_allow, irq}, 4'hC);
    rd(12'h004, 32'h30); apb(1'b1, 12'h004, 32'h03); tick(2);
    chk({deep_sleep_allow, deep_sleep_kind_select}, 2'h3);
    por_n <= 0; tick(4); por_n <= 1; tick(4);
    chk({undervolt_trip_select, warning_trip_select}, 2'h0);
    supply_lvl <= 2; reset_n <= 0; tick(2); reset_n <= 1; tick(6);
    rd(12'h004, {24'h0, below(2, 0, 0), 7'h0});
    conclude;
  end
endmodule // tb
